//--- hdl/frame_crc_pkg.sv
`default_nettype none

package frame_crc_pkg;

	// Check word arithmetic.
	localparam int          CRC_WIDTH    = 16;
	localparam logic [15:0] CRC_POLY     = 16'h1021;
	localparam logic [15:0] CRC_INIT     = 16'hFFFF;
	localparam int          HAMMING_BITS = 8;

	// Register port byte addresses.
	localparam logic [7:0] ADDR_CONFIG      = 8'h00;
	localparam logic [7:0] ADDR_STATUS      = 8'h04;
	localparam logic [7:0] ADDR_ERRCNT      = 8'h08;
	localparam logic [7:0] ADDR_LASTCMD     = 8'h0C;
	localparam logic [7:0] ADDR_DEVREG_BASE = 8'h20;
	localparam int         DEVREG_COUNT     = 8;

	// Field positions of digital_system_config and of the status register.
	localparam int         CFG_CRC_EN    = 0;
	localparam int         CFG_COVER_ALL = 1;
	localparam int         CFG_CONST_LEN = 2;
	localparam int         CFG_HAMMING   = 3;
	localparam int         CFG_CHAN_EN   = 4;
	localparam logic [7:0] CFG_RESET     = 8'hF0;
	localparam int         STAT_FAULT    = 0;

	// Command opcodes in the top three bits of a command word.
	localparam logic [2:0] OPC_SINGLE_WRITE = 3'h2;
	localparam logic [2:0] OPC_MULTI_WRITE  = 3'h3;

	// Timing.
	localparam int         CLK_PERIOD_NS   = 25;
	localparam int         CONV_PERIOD_NS  = 125000;
	localparam int         CONV_CYCLES_DEF = CONV_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [2:0] MODE_SETTLE     = 3'h4;

	typedef enum logic [2:0] {
		FR_IDLE   = 3'b001,
		FR_ACTIVE = 3'b010,
		FR_DONE   = 3'b100
	} frameState_t;

	typedef enum logic [1:0] {
		IF_ASYNC       = 2'b00,
		IF_SYNC_MASTER = 2'b01,
		IF_SYNC_SLAVE  = 2'b10
	} ifMode_t;

endpackage

`default_nettype wire

//--- hdl/crc_bit_step.sv
`default_nettype none

module crc_bit_step (
	// Remainder and serial bit in.
	input  wire logic [frame_crc_pkg::CRC_WIDTH-1:0] crcIn,
	input  wire logic                                dataBit,
	// Remainder after the bit.
	output logic      [frame_crc_pkg::CRC_WIDTH-1:0] crcOut
);
	import frame_crc_pkg::*;

	// One bit at a time, MSB first, gives the same remainder as the bytewise XOR-and-shift.
	always_comb begin
		crcOut = {crcIn[14:0], 1'b0} ^ ((crcIn[15] ^ dataBit) ? CRC_POLY : 16'h0000);
	end

endmodule // crc_bit_step

`default_nettype wire

//--- hdl/spi_frame_crc_checker.sv
// Decided for this implementation: the strobed register port and the address map.
`default_nettype none

module spi_frame_crc_checker #(
	parameter int CHANNELS    = 4,
	parameter int WORD_BITS   = 24,
	parameter int CONV_CYCLES = frame_crc_pkg::CONV_CYCLES_DEF
) (
	// Clock and reset.
	input  wire logic                          sys_clk,
	input  wire logic                          resetn,
	// Serial link pins.
	input  wire logic                          csN,
	input  wire logic                          sclk,
	input  wire logic                          din,
	output logic                               dout,
	output logic                               doutOe,
	output logic                               conversionReadyN,
	// Interface select pin, sensed through a weak pull-up and a weak pull-down.
	input  wire logic                          selSenseUp,
	input  wire logic                          selSenseDown,
	output logic [1:0]                         interfaceMode,
	// Converter samples on the system clock.
	input  wire logic [CHANNELS*WORD_BITS-1:0] sampleData,
	// Register port.
	input  wire logic [7:0]                    regAddr,
	input  wire logic [31:0]                   regWrData,
	input  wire logic                          regWr,
	input  wire logic                          regRd,
	output logic [31:0]                        regRdData
);
	import frame_crc_pkg::*;

	localparam logic [4:0] LAST_BIT = 5'(WORD_BITS - 1);

	typedef logic [CHANNELS-1:0][WORD_BITS-1:0] samples_t;

	typedef struct packed {
		logic                             csMeta;
		logic                             csSync;
		logic                             sclkMeta;
		logic                             sclkSync;
		logic                             sclkPrev;
		logic                             dinMeta;
		logic                             dinSync;
		logic                             upMeta;
		logic                             upSync;
		logic                             dnMeta;
		logic                             dnSync;
		logic [2:0]                       settle;
		logic                             modeLatched;
		ifMode_t                          mode;
		frameState_t                      fstate;
		logic [7:0]                       cfg;
		logic                             fault;
		logic [7:0]                       errCnt;
		logic [15:0]                      lastCmd;
		logic [15:0]                      pendCmd;
		logic                             pendValid;
		logic                             isMulti;
		logic                             crcChecked;
		logic                             mismatch;
		logic [2:0]                       multiAddr;
		logic [7:0]                       multiCount;
		logic [15:0]                      crcIn;
		logic [15:0]                      crcInMark;
		logic [15:0]                      crcOut;
		logic [4:0]                       inBit;
		logic [4:0]                       outBit;
		logic [7:0]                       inWord;
		logic [7:0]                       outWord;
		logic [WORD_BITS-1:0]             inShift;
		logic [WORD_BITS-1:0]             outShift;
		logic [DEVREG_COUNT-1:0][7:0]     devReg;
		samples_t                         sample;
		logic [15:0]                      convCnt;
		logic                             convReadyN;
		logic                             dout;
		logic                             doutOe;
		logic [31:0]                      rdData;
	} state_t;

	state_t               q;
	state_t               d;
	logic [7:0]           fw;
	logic [4:0]           covBits;
	logic [7:0]           inCrcIdx;
	logic                 riseEdge;
	logic                 fallEdge;
	logic                 inCovered;
	logic                 outCovered;
	logic                 filler;
	logic                 crcFail;
	logic                 convTick;
	logic [WORD_BITS-1:0] inWordFull;
	logic [WORD_BITS-1:0] wordVal;
	logic [15:0]          cmdWord;
	logic [15:0]          crcInStep;
	logic [15:0]          crcOutStep;

	// Frame length in words, check word slot included.
	function automatic logic [7:0] frameWords(logic [7:0] cfg);
		logic [7:0] n;
		n = 8'(CHANNELS + 2);
		if (!cfg[CFG_CONST_LEN]) begin
			n = 8'h02;
			for (int i = 0; i < CHANNELS; i++) begin
				n = n + 8'(cfg[CFG_CHAN_EN + i]);
			end
		end
		return n;
	endfunction

	// Word w (from 1) carries the w-th enabled channel, or channel w-1 at constant length.
	function automatic logic [WORD_BITS-1:0] dataWord(logic [7:0] w, logic [7:0] cfg,
			samples_t s);
		logic [7:0] k;
		dataWord = '0;
		k = 8'h00;
		for (int i = 0; i < CHANNELS; i++) begin
			if (cfg[CFG_CONST_LEN] || cfg[CFG_CHAN_EN + i]) begin
				k = k + 8'h01;
				if (k == w) begin
					dataWord = s[i];
				end
			end
		end
	endfunction

	crc_bit_step u_inStep (
		.crcIn   (q.crcIn),
		.dataBit (q.dinSync),
		.crcOut  (crcInStep)
	);

	crc_bit_step u_outStep (
		.crcIn   (q.crcOut),
		.dataBit (wordVal[WORD_BITS-1]),
		.crcOut  (crcOutStep)
	);

	always_comb begin
		d = q;
		inCovered = 1'b0;
		outCovered = 1'b0;
		filler = 1'b0;
		crcFail = 1'b0;
		inWordFull = '0;
		cmdWord = 16'h0000;
		wordVal = '0;
		fw = frameWords(q.cfg);
		covBits = q.cfg[CFG_HAMMING] ? 5'(WORD_BITS - HAMMING_BITS) : 5'(WORD_BITS);
		inCrcIdx = (q.isMulti && q.multiCount >= fw - 8'h01) ? q.multiCount + 8'h01
			: fw - 8'h01;

		// Pin synchronisers; only the second stage, and the third for the serial clock, is ever looked at.
		d.csMeta = csN;
		d.csSync = q.csMeta;
		d.sclkMeta = sclk;
		d.sclkSync = q.sclkMeta;
		d.sclkPrev = q.sclkSync;
		d.dinMeta = din;
		d.dinSync = q.dinMeta;
		d.upMeta = selSenseUp;
		d.upSync = q.upMeta;
		d.dnMeta = selSenseDown;
		d.dnSync = q.dnMeta;

		// Clock idles low; shift out on the rising edge, capture on the falling one.
		riseEdge = q.sclkSync && !q.sclkPrev && q.fstate == FR_ACTIVE && !q.csSync;
		fallEdge = !q.sclkSync && q.sclkPrev && q.fstate == FR_ACTIVE && !q.csSync;

		// The pin is read once, after the synchronisers have filled.
		if (!q.modeLatched) begin
			if (q.settle == MODE_SETTLE) begin
				d.modeLatched = 1'b1;
				if (q.upSync && q.dnSync) begin
					d.mode = IF_ASYNC;
				end else if (!q.upSync && !q.dnSync) begin
					d.mode = IF_SYNC_MASTER;
				end else begin
					d.mode = IF_SYNC_SLAVE;
				end
			end else begin
				d.settle = q.settle + 3'h1;
			end
		end

		// Conversion timebase; a sample landing during a frame is dropped.
		convTick = q.convCnt == 16'(CONV_CYCLES - 1);
		d.convCnt = convTick ? 16'h0000 : q.convCnt + 16'h0001;
		if (convTick && q.modeLatched && q.mode == IF_ASYNC) begin
			d.convReadyN = 1'b0;
			if (q.fstate == FR_IDLE) begin
				d.sample = sampleData;
			end
		end

		case (q.fstate)
			FR_IDLE: begin
				if (!q.csSync) begin
					d.fstate = FR_ACTIVE;
					d.crcIn = CRC_INIT;
					d.crcInMark = CRC_INIT;
					d.crcOut = CRC_INIT;
					d.inBit = 5'h00;
					d.outBit = 5'h00;
					d.inWord = 8'h00;
					d.outWord = 8'h00;
					d.pendValid = 1'b0;
					d.isMulti = 1'b0;
					d.crcChecked = 1'b0;
					d.mismatch = 1'b0;
					d.doutOe = 1'b1;
				end
			end
			FR_ACTIVE: begin
				if (q.csSync) begin
					d.fstate = FR_DONE;
					d.doutOe = 1'b0;
					d.dout = 1'b0;
					d.convReadyN = 1'b1;
				end
			end
			FR_DONE: begin
				d.fstate = FR_IDLE;
				// Single writes take effect only once the frame has closed; multi-write data words land as each one arrives.
				if (q.pendValid && (!q.cfg[CFG_CRC_EN] || (q.crcChecked && !q.mismatch))) begin
					d.lastCmd = q.pendCmd;
					if (q.pendCmd[15:13] == OPC_SINGLE_WRITE) begin
						d.devReg[q.pendCmd[10:8]] = q.pendCmd[7:0];
					end
				end else if (q.isMulti) begin
					d.lastCmd = q.pendCmd;
				end
			end
			default: begin
				d.fstate = FR_IDLE;
			end
		endcase

		if (fallEdge) begin
			inWordFull = {q.inShift[WORD_BITS-2:0], q.dinSync};
			d.inShift = inWordFull;
			inCovered = q.cfg[CFG_CRC_EN] && q.inBit < covBits && q.inWord != inCrcIdx;
			if (inCovered) begin
				d.crcIn = crcInStep;
			end
			if (q.inBit == LAST_BIT) begin
				d.inBit = 5'h00;
				if (q.inWord != 8'hFF) begin
					d.inWord = q.inWord + 8'h01;
				end
				cmdWord = inWordFull[WORD_BITS-1 -: 16];
				filler = q.inWord != 8'h00 && (!q.isMulti || q.inWord > q.multiCount);
				// A filler word is only known to be zero at its end, so roll back.
				if (!q.cfg[CFG_COVER_ALL] && filler && inWordFull == '0) begin
					d.crcIn = q.crcInMark;
				end
				d.crcInMark = d.crcIn;
				if (q.inWord == 8'h00) begin
					d.pendCmd = cmdWord;
					d.pendValid = 1'b1;
					d.isMulti = cmdWord[15:13] == OPC_MULTI_WRITE;
					d.multiAddr = cmdWord[10:8];
					d.multiCount = cmdWord[7:0];
				end else if (q.isMulti && q.inWord <= q.multiCount) begin
					d.devReg[q.multiAddr] = inWordFull[WORD_BITS-1 -: 8];
					d.multiAddr = q.multiAddr + 3'h1;
				end
				if (q.cfg[CFG_CRC_EN] && q.inWord == inCrcIdx) begin
					d.crcChecked = 1'b1;
					d.mismatch = cmdWord != q.crcIn;
					crcFail = cmdWord != q.crcIn;
				end
			end else begin
				d.inBit = q.inBit + 5'h01;
			end
		end

		if (crcFail) begin
			d.fault = 1'b1;
			d.errCnt = q.errCnt + 8'h01;
		end

		if (riseEdge) begin
			if (q.outBit == 5'h00) begin
				if (q.outWord == 8'h00) begin
					wordVal[WORD_BITS-1 -: 16] = q.lastCmd;
				end else if (q.outWord == fw - 8'h01) begin
					wordVal[WORD_BITS-1 -: 16] = q.cfg[CFG_CRC_EN] ? q.crcOut : 16'h0000;
				end else if (q.outWord < fw - 8'h01) begin
					wordVal = dataWord(q.outWord, q.cfg, q.sample);
				end
				// Words past the check slot stay zero: multi-write padding.
				if (q.cfg[CFG_HAMMING]) begin
					wordVal[HAMMING_BITS-1:0] = '0;
				end
			end else begin
				wordVal = q.outShift;
			end
			d.dout = wordVal[WORD_BITS-1];
			d.outShift = {wordVal[WORD_BITS-2:0], 1'b0};
			outCovered = q.cfg[CFG_CRC_EN] && q.outBit < covBits && q.outWord < fw - 8'h01;
			if (outCovered) begin
				d.crcOut = crcOutStep;
			end
			if (q.outBit == LAST_BIT) begin
				d.outBit = 5'h00;
				if (q.outWord != 8'hFF) begin
					d.outWord = q.outWord + 8'h01;
				end
			end else begin
				d.outBit = q.outBit + 5'h01;
			end
		end

		// Register port. Changing the configuration mid-frame shifts the frame layout.
		if (regWr) begin
			if (regAddr == ADDR_CONFIG) begin
				d.cfg = regWrData[7:0];
			end else if (regAddr == ADDR_STATUS && regWrData[STAT_FAULT] && !crcFail) begin
				d.fault = 1'b0;
			end
		end
		d.rdData = 32'h0000_0000;
		if (regRd) begin
			if (regAddr == ADDR_CONFIG) begin
				d.rdData = {24'h00_0000, q.cfg};
			end else if (regAddr == ADDR_STATUS) begin
				d.rdData = {28'h000_0000, q.fstate != FR_IDLE, q.mode, q.fault};
			end else if (regAddr == ADDR_ERRCNT) begin
				d.rdData = {24'h00_0000, q.errCnt};
				d.errCnt = crcFail ? 8'h01 : 8'h00;
			end else if (regAddr == ADDR_LASTCMD) begin
				d.rdData = {16'h0000, q.lastCmd};
			end else if (regAddr[7:5] == ADDR_DEVREG_BASE[7:5] && regAddr[1:0] == 2'h0) begin
				d.rdData = {24'h00_0000, q.devReg[regAddr[4:2]]};
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			q <= '0;
			q.csMeta <= 1'b1;
			q.csSync <= 1'b1;
			q.fstate <= FR_IDLE;
			q.mode <= IF_ASYNC;
			q.cfg <= CFG_RESET;
			q.crcIn <= CRC_INIT;
			q.crcInMark <= CRC_INIT;
			q.crcOut <= CRC_INIT;
			q.convReadyN <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign dout = q.dout;
	assign doutOe = q.doutOe;
	assign conversionReadyN = q.convReadyN;
	assign interfaceMode = q.mode;
	assign regRdData = q.rdData;

	// Checks.
	logic [7:0] multiData;
	logic       errRead;
	assign multiData = inWordFull[WORD_BITS-1 -: 8];
	assign errRead = regRd && regAddr == ADDR_ERRCNT;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	sequence s_cs_rise;
		q.fstate == FR_ACTIVE && q.csSync;
	endsequence

	sequence s_closed;
		!doutOe ##1 q.fstate == FR_IDLE;
	endsequence

	property p_crc_init;
		q.fstate == FR_IDLE && !q.csSync |=> q.crcIn == CRC_INIT && q.crcOut == CRC_INIT;
	endproperty
	a_crc_init: assert property (p_crc_init) else $error("remainder not restarted");

	property p_in_step;
		fallEdge && inCovered && q.inBit != LAST_BIT |=> q.crcIn == $past(crcInStep);
	endproperty
	a_in_step: assert property (p_in_step) else $error("input remainder step wrong");

	property p_fail_count;
		crcFail && !errRead |=> q.fault && q.errCnt == $past(q.errCnt) + 8'h01;
	endproperty
	a_fail_count: assert property (p_fail_count) else $error("failure not recorded");

	property p_err_wrap;
		crcFail && !errRead && q.errCnt == 8'hFF |=> q.errCnt == 8'h00;
	endproperty
	a_err_wrap: assert property (p_err_wrap) else $error("counter did not wrap");

	property p_err_clear;
		errRead && !crcFail |=> q.errCnt == 8'h00 && regRdData[7:0] == $past(q.errCnt);
	endproperty
	a_err_clear: assert property (p_err_clear) else $error("read did not clear");

	property p_no_exec;
		q.fstate == FR_DONE && q.mismatch && !q.isMulti |=>
			q.devReg == $past(q.devReg) && q.lastCmd == $past(q.lastCmd);
	endproperty
	a_no_exec: assert property (p_no_exec) else $error("bad command executed");

	property p_cs_release;
		s_cs_rise |=> s_closed;
	endproperty
	a_cs_release: assert property (p_cs_release) else $error("frame not released");

	property p_multi_write;
		fallEdge && q.inBit == LAST_BIT && q.isMulti && q.inWord != 8'h00 &&
			q.inWord <= q.multiCount |=> q.devReg[$past(q.multiAddr)] == $past(multiData);
	endproperty
	a_multi_write: assert property (p_multi_write) else $error("multi write missed");

	property p_ready_mode;
		q.mode != IF_ASYNC |-> conversionReadyN;
	endproperty
	a_ready_mode: assert property (p_ready_mode) else $error("ready outside async");

	property p_mode_hold;
		q.modeLatched |=> q.modeLatched && q.mode == $past(q.mode);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed");

	property p_const_len;
		q.cfg[CFG_CONST_LEN] |-> fw == 8'(CHANNELS + 2);
	endproperty
	a_const_len: assert property (p_const_len) else $error("frame length wrong");

endmodule // spi_frame_crc_checker

`default_nettype wire

//--- bench/spi_host_model.sv
`default_nettype none

module spi_host_model (
	// Pacing clock.
	input  wire logic sys_clk,
	// Host side of the serial link.
	output logic      csN,
	output logic      sclk,
	output logic      din,
	input  wire logic dout
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [23:0] txWords [16];
	logic [23:0] rxWords [16];
	logic        dinQ = 1'b0;
	logic        idleQ = 1'b0;

	initial begin
		csN = 1'b1;
		sclk = 1'b0;
		for (int k = 0; k < 16; k++) begin
			txWords[k] = 24'h000000;
		end
	end

	// A released data line keeps toggling so that a stale level can never pass for a bit.
	always @(posedge sys_clk) begin
		idleQ <= ~idleQ;
	end
	assign din = csN ? idleQ : dinQ;

	// Data change with the rising edge and must hold across the falling edge, which the
	// device sees a few system clocks late; the clock idles low between frames.
	task automatic run_frame(input int nWords, input int stopBit);
		@(posedge sys_clk);
		csN <= 1'b0;
		repeat (6) @(posedge sys_clk);
		for (int k = 0; k < nWords * 24 && k != stopBit; k++) begin
			sclk <= 1'b1;
			dinQ <= txWords[k / 24][23 - k % 24];
			repeat (4) @(posedge sys_clk);
			sclk <= 1'b0;
			repeat (2) @(posedge sys_clk);
			rxWords[k / 24][23 - k % 24] = dout;
			repeat (2) @(posedge sys_clk);
		end
		sclk <= 1'b0;
		csN <= 1'b1;
		repeat (8) @(posedge sys_clk);
	endtask
endmodule // spi_host_model

`default_nettype wire

//--- bench/spi_frame_crc_checker_test.sv
`default_nettype none

module spi_frame_crc_checker_test;
	timeunit 1ns;
	timeprecision 1ps;
	import frame_crc_pkg::*;

	localparam int CH   = 4;
	localparam int CONV = 200;

	logic        sys_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        csN;
	logic        sclk;
	logic        din;
	logic        dout;
	logic        doutOe;
	logic        conversionReadyN;
	logic        selSenseUp = 1'b0;
	logic        selSenseDown = 1'b0;
	logic [1:0]  interfaceMode;
	logic [95:0] sampleData = {24'hD40001, 24'hC30002, 24'hB20003, 24'hA10004};
	logic [7:0]  regAddr = 8'h00;
	logic [31:0] regWrData = 32'h00000000;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic [31:0] regRdData;
	logic [31:0] rd;
	logic [15:0] lastCmd = 16'h0000;
	logic [23:0] expW [16];
	int          bad_count = 0;
	int          samples_checked = 0;

	always #12.5 sys_clk = ~sys_clk;

	spi_frame_crc_checker #(.CHANNELS(CH), .WORD_BITS(24), .CONV_CYCLES(CONV))
		spi_frame_crc_checker_inst (
		.sys_clk(sys_clk), .resetn(resetn), .csN(csN), .sclk(sclk), .din(din),
		.dout(dout), .doutOe(doutOe), .conversionReadyN(conversionReadyN),
		.selSenseUp(selSenseUp), .selSenseDown(selSenseDown), .interfaceMode(interfaceMode),
		.sampleData(sampleData), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData)
	);

	spi_host_model spi_host_model_inst (
		.sys_clk(sys_clk), .csN(csN), .sclk(sclk), .din(din), .dout(dout)
	);

	task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR at %0t: register value %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic check_link(input logic [23:0] got, input logic [23:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR at %0t: link word %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask

	task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1;
		rd = regRdData;
		check_reg(rd, exp);
	endtask

	function automatic logic [15:0] crc_of(input logic [23:0] w [16], input int n,
		input logic ham, input logic dropZero);
		logic [15:0] c;
		c = CRC_INIT;
		for (int k = 0; k < n; k++) begin
			for (int b = 23; b >= 0; b--) begin
				if (!(ham && b < 8) && !(dropZero && k > 0 && w[k] == 24'h000000))
					c = {c[14:0], 1'b0} ^ ((c[15] ^ w[k][b]) ? CRC_POLY : 16'h0000);
			end
		end
		return c;
	endfunction

	// Data words of a multi-register write must already sit in the host buffer.
	task automatic send(input logic [15:0] cmd, input logic [7:0] cfg, input int n,
		input int chk, input logic bad, input logic exec);
		int fw;
		int k;
		fw = cfg[CFG_CONST_LEN] ? CH + 2 : 2 + $countones(cfg[7:4]);
		// The device must run the same layout and coverage that the expected words assume.
		reg_write(ADDR_CONFIG, {24'h000000, cfg});
		spi_host_model_inst.txWords[0] = {cmd, cfg[CFG_HAMMING] ? 8'hA5 : 8'h00};
		spi_host_model_inst.txWords[chk] = cfg[CFG_CRC_EN] ? {crc_of(spi_host_model_inst.txWords,
			chk, cfg[CFG_HAMMING], !cfg[CFG_COVER_ALL]) ^ {15'h0000, bad}, 8'h00} : 24'h0;
		expW[0] = {lastCmd, 8'h00};
		for (int j = 1; j < 16; j++) begin
			expW[j] = 24'h000000;
		end
		k = 1;
		for (int i = 0; i < CH; i++) begin
			if (cfg[CFG_CHAN_EN + i]) begin
				expW[k] = sampleData[i * 24 +: 24];
				k++;
			end
		end
		expW[fw - 1] = cfg[CFG_CRC_EN]
			? {crc_of(expW, fw - 1, cfg[CFG_HAMMING], 1'b0), 8'h00} : 24'h0;
		spi_host_model_inst.run_frame(n, -1);
		for (int j = 0; j < n; j++) begin
			if (!cfg[CFG_HAMMING] || j == fw - 1)
				check_link(spi_host_model_inst.rxWords[j], expW[j]);
		end
		if (exec)
			lastCmd = cmd;
		for (int j = 0; j < 16; j++) begin
			spi_host_model_inst.txWords[j] = 24'h000000;
		end
	endtask

	task automatic test_mode();
		repeat (8) @(posedge sys_clk);
		selSenseUp <= 1'b1;
		repeat (4) @(posedge sys_clk);
		check_reg({30'h0, interfaceMode}, 32'h1);
		resetn <= 1'b0;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (8) @(posedge sys_clk);
		check_reg({30'h0, interfaceMode}, 32'h2);
		selSenseDown <= 1'b1;
		resetn <= 1'b0;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (CONV - 4) @(posedge sys_clk);
		check_reg({31'h0, conversionReadyN}, 32'h1);
		repeat (8) @(posedge sys_clk);
		check_reg({29'h0, interfaceMode, conversionReadyN}, 32'h0);
		$display("done: mode latch and conversion ready");
	endtask

	task automatic test_frames();
		expect_reg(ADDR_CONFIG, 32'h000000F0);
		expect_reg(8'h10, 32'h0);
		reg_write(ADDR_ERRCNT, 32'h55);
		expect_reg(ADDR_ERRCNT, 32'h0);
		send(16'h435A, 8'hF7, 6, 5, 1'b0, 1'b1);
		expect_reg(ADDR_DEVREG_BASE + 8'h0C, 32'h5A);
		send(16'h4211, 8'hF7, 6, 5, 1'b1, 1'b0);
		send(16'h4211, 8'hF7, 6, 5, 1'b1, 1'b0);
		expect_reg(ADDR_DEVREG_BASE + 8'h08, 32'h0);
		expect_reg(ADDR_STATUS, 32'h1);
		expect_reg(ADDR_ERRCNT, 32'h2);
		expect_reg(ADDR_ERRCNT, 32'h0);
		reg_write(ADDR_STATUS, 32'h1);
		expect_reg(ADDR_STATUS, 32'h0);
		send(16'h4133, 8'hF5, 6, 5, 1'b0, 1'b1);
		expect_reg(ADDR_DEVREG_BASE + 8'h04, 32'h33);
		$display("done: verified, refused and filler-word single writes");
	endtask

	task automatic test_multi();
		for (int k = 1; k <= 6; k++) begin
			spi_host_model_inst.txWords[k] = {8'h10 + 8'(k), 16'h0000};
		end
		send(16'h6206, 8'hF7, 8, 7, 1'b1, 1'b1);
		for (int k = 1; k <= 6; k++) begin
			expect_reg(ADDR_DEVREG_BASE + 8'(4 * k + 4), 32'(8'h10 + 8'(k)));
		end
		expect_reg(ADDR_STATUS, 32'h1);
		reg_write(ADDR_STATUS, 32'h1);
		$display("done: multi-register write");
	endtask

	task automatic test_short_and_off();
		send(16'h4477, 8'h3B, 4, 3, 1'b0, 1'b1);
		expect_reg(ADDR_DEVREG_BASE + 8'h10, 32'h77);
		spi_host_model_inst.run_frame(6, 30);
		check_reg({30'h0, doutOe, dout}, 32'h0);
		send(16'h4599, 8'hF4, 6, 5, 1'b0, 1'b1);
		expect_reg(ADDR_DEVREG_BASE + 8'h14, 32'h99);
		$display("done: short frame, abort and unchecked frame");
	endtask

	task automatic report_and_stop();
		$display("Compared %0d values, %0d mismatches", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		test_mode();
		test_frames();
		test_multi();
		test_short_and_off();
		report_and_stop();
	end

	// The whole run needs well under a third of this span.
	initial begin
		#1000000;
		bad_count++;
		$display("ERROR at %0t: run did not finish in time", $time);
		report_and_stop();
	end
endmodule // spi_frame_crc_checker_test

`default_nettype wire
